// file: rtl/ilc_blink_engine.sv
// one lamp blink generator: queues requested blinks and plays them at a fixed period
// assumes tick is a one-cycle pulse from the millisecond divider
module ilc_blink_engine #(
    parameter int unsigned CNT_W        = 3,
    parameter int unsigned ON_TICKS     = 50,
    parameter int unsigned PERIOD_TICKS = 100
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             tick,
    input  wire logic             trig,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_cnt,
    output logic                  busy,
    output logic                  blink
);
    localparam int unsigned PH_W = $clog2(PERIOD_TICKS + 1);

    logic [CNT_W-1:0] pend_r;
    logic [PH_W-1:0]  phase_r;
    logic             active_r;
    logic             start;

    assign start = !active_r && (pend_r != '0);

    // pending blinks; a new request in the start cycle is kept, not lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_r <= '0;
        end else if (load) begin
            pend_r <= load_cnt;
        end else if (trig && !start) begin
            if (pend_r != {CNT_W{1'b1}}) begin
                pend_r <= pend_r + CNT_W'(1);
            end
        end else if (start && !trig) begin
            pend_r <= pend_r - CNT_W'(1);
        end
    end

    // one blink window per pending request, ending on the PERIOD_TICKS-th tick after start
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_r <= 1'b0;
            phase_r  <= '0;
        end else if (start) begin
            active_r <= 1'b1;
            phase_r  <= '0;
        end else if (active_r && tick) begin
            if (phase_r == PH_W'(PERIOD_TICKS - 1)) begin
                active_r <= 1'b0;
            end
            phase_r <= phase_r + PH_W'(1);
        end
    end

    assign busy  = active_r || (pend_r != '0);
    assign blink = active_r && (phase_r < PH_W'(ON_TICKS));

endmodule // ilc_blink_engine

// file: rtl/ilc_lamp_ctrl.sv
// indicator lamp controller: register port, boot pattern, activity and link lamp drive
// assumes events are one-cycle pulses and status inputs are levels, all on clk
module ilc_lamp_ctrl
    import ilc_pkg::*;
#(
    parameter int unsigned TICK_DIV = ilc_pkg::TICK_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire ilc_pkg::ilc_reg_req_type reg_req,
    output logic [15:0]                  reg_rdata,
    output logic                         reg_rvalid,
    input  wire ilc_pkg::ilc_event_type  ev,
    input  wire ilc_pkg::ilc_status_type st,
    input  wire logic [15:0]             boot_mode_stored,
    output logic [15:0]                  boot_mode_keep,
    output logic                         lamp_link,
    output logic                         lamp_activity
);
    import ilc_pkg::*;

    localparam int unsigned DIV_W  = $clog2(TICK_DIV);
    localparam int unsigned BOOT_W = $clog2(BOOT_BLINK_MS + 1);
    localparam int unsigned POLL_W = $clog2(POLL_PERIOD_MS);
    localparam int unsigned RAP_W  = $clog2(RAPID_HALF_MS);
    localparam int unsigned UNI_W  = $clog2(UNISON_HALF_MS);

    typedef enum logic [1:0] {
        ILC_CAPTURE,
        ILC_BOOT,
        ILC_RUN
    } ilc_phase_type;

    ilc_phase_type     phase_r;
    logic [DIV_W-1:0]  div_r;
    logic              tick_r;
    logic [BOOT_W-1:0] boot_cnt_r;
    logic [RAP_W-1:0]  rap_cnt_r;
    logic              rap_tog_r;
    logic [UNI_W-1:0]  uni_cnt_r;
    logic              uni_tog_r;
    logic [POLL_W-1:0] poll_cnt_r;
    logic              poll_load;
    logic [15:0]       lamp_mode_r;
    logic [15:0]       lamp_mode_boot_r;
    logic              man_link_r;
    logic              man_act_r;
    logic              enumerated_r;
    logic [2:0]        stage_prev_r;
    logic              stage_load;
    logic              act_trig;
    logic              link_trig;
    logic              link_load;
    logic [PEND_W-1:0] link_load_cnt;
    logic              act_blink;
    logic              link_blink;
    logic              act_nxt;
    logic              link_nxt;
    logic              lamp_act_r;
    logic              lamp_link_r;
    logic [15:0]       rdata_r;
    logic              rvalid_r;

    // millisecond enable; everything slower runs off this pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else if (div_r == DIV_W'(TICK_DIV - 1)) begin
            div_r  <= '0;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + DIV_W'(1);
            tick_r <= 1'b0;
        end
    end

    // pattern togglers: fast one for the boot blink, slow one for update patterns
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rap_cnt_r <= '0;
            rap_tog_r <= 1'b1;
            uni_cnt_r <= '0;
            uni_tog_r <= 1'b1;
        end else if (tick_r) begin
            if (rap_cnt_r == RAP_W'(RAPID_HALF_MS - 1)) begin
                rap_cnt_r <= '0;
                rap_tog_r <= !rap_tog_r;
            end else begin
                rap_cnt_r <= rap_cnt_r + RAP_W'(1);
            end
            if (uni_cnt_r == UNI_W'(UNISON_HALF_MS - 1)) begin
                uni_cnt_r <= '0;
                uni_tog_r <= !uni_tog_r;
            end else begin
                uni_cnt_r <= uni_cnt_r + UNI_W'(1);
            end
        end
    end

    // power-up sequence: capture stored mode at release, then the boot blink window
    // boot blink window
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_r    <= ILC_CAPTURE;
            boot_cnt_r <= '0;
        end else begin
            case (phase_r)
                ILC_CAPTURE: begin
                    phase_r <= ILC_BOOT;
                end
                ILC_BOOT: begin
                    if (tick_r) begin
                        if (boot_cnt_r == BOOT_W'(BOOT_BLINK_MS - 1)) begin
                            phase_r <= ILC_RUN;
                        end
                        boot_cnt_r <= boot_cnt_r + BOOT_W'(1);
                    end
                end
                ILC_RUN: begin
                    phase_r <= ILC_RUN;
                end
                default: begin
                    phase_r <= ILC_CAPTURE;
                end
            endcase
        end
    end

    // mode registers; the stored boot mode is taken only after reset release
    // boot mode applied
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lamp_mode_r      <= MODE_RESET;
            lamp_mode_boot_r <= MODE_RESET;
        end else if (phase_r == ILC_CAPTURE) begin
            lamp_mode_r      <= boot_mode_stored;
            lamp_mode_boot_r <= boot_mode_stored;
        end else if (reg_req.wr) begin
            if (reg_req.addr == ADDR_LAMP_MODE) begin
                lamp_mode_r <= reg_req.wdata;
            end
            if (reg_req.addr == ADDR_LAMP_MODE_BOOT) begin
                lamp_mode_boot_r <= reg_req.wdata;
            end
        end
    end

    // manual lamp levels; only accepted while the mode is manual
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            man_link_r <= 1'b0;
            man_act_r  <= 1'b0;
        end else if (reg_req.wr && (lamp_mode_r == MODE_MANUAL)) begin
            if (reg_req.addr == ADDR_MANUAL_LINK) begin
                man_link_r <= reg_req.wdata[MANUAL_ON_BIT];
            end
            if (reg_req.addr == ADDR_MANUAL_ACTIVITY) begin
                man_act_r <= reg_req.wdata[MANUAL_ON_BIT];
            end
        end
    end

    // read port; write-only and unmapped addresses answer zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_req.rd;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    ADDR_LAMP_MODE:      rdata_r <= lamp_mode_r;
                    ADDR_LAMP_MODE_BOOT: rdata_r <= lamp_mode_boot_r;
                    default:             rdata_r <= '0;
                endcase
            end
        end
    end

    // enumeration latch and firmware stage change detect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enumerated_r <= 1'b0;
            stage_prev_r <= '0;
        end else begin
            stage_prev_r <= st.fw_stage;
            if (ev.enum_done) begin
                enumerated_r <= 1'b1;
            end
        end
    end

    // dashboard polling cadence; restarts whenever polling stops
    always_ff @(posedge clk) begin
        if (!rst_n || !st.dashboard_poll) begin
            poll_cnt_r <= '0;
        end else if (tick_r) begin
            if (poll_cnt_r == POLL_W'(POLL_PERIOD_MS - 1)) begin
                poll_cnt_r <= '0;
            end else begin
                poll_cnt_r <= poll_cnt_r + POLL_W'(1);
            end
        end
    end

    assign poll_load = st.dashboard_poll && tick_r &&
                       (poll_cnt_r == POLL_W'(POLL_PERIOD_MS - 1));

    assign act_trig   = ev.script_access || ev.stream_prep;
    assign stage_load = (st.fw_stage != stage_prev_r) && (st.fw_stage != 3'h0);

    assign link_trig = ev.cmd_packet || ev.stream_xfer;
    assign link_load     = ev.enum_done || poll_load;
    assign link_load_cnt = ev.enum_done ? PEND_W'(ENUM_BLINKS) : PEND_W'(POLL_BLINKS);

    ilc_blink_engine #(
        .CNT_W        (PEND_W),
        .ON_TICKS     (BLINK_ON_MS),
        .PERIOD_TICKS (BLINK_PERIOD_MS)
    ) u_act_blink (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick     (tick_r),
        .trig     (act_trig),
        .load     (stage_load),
        .load_cnt (PEND_W'(st.fw_stage)),
        .busy     (),
        .blink    (act_blink)
    );

    // period caps rate at 10 Hz
    ilc_blink_engine #(
        .CNT_W        (PEND_W),
        .ON_TICKS     (BLINK_ON_MS),
        .PERIOD_TICKS (BLINK_PERIOD_MS)
    ) u_link_blink (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick     (tick_r),
        .trig     (link_trig),
        .load     (link_load),
        .load_cnt (link_load_cnt),
        .busy     (),
        .blink    (link_blink)
    );

    // lamp selection; manual and off modes override every pattern
    always_comb begin
        act_nxt  = 1'b1;
        link_nxt = enumerated_r;
        if (lamp_mode_r == MODE_MANUAL) begin
            act_nxt  = man_act_r;
            link_nxt = man_link_r;
        end else if (lamp_mode_r == MODE_OFF) begin
            act_nxt  = 1'b0;
            link_nxt = 1'b0;
        end else if (phase_r != ILC_RUN) begin
            act_nxt  = rap_tog_r;
            link_nxt = rap_tog_r;
        end else if (st.image_copy) begin
            act_nxt  = uni_tog_r;
            link_nxt = !uni_tog_r;
        end else if (st.checksum_busy) begin
            act_nxt  = uni_tog_r;
            link_nxt = uni_tog_r;
        end else if (lamp_mode_r == MODE_LOW) begin
            // low power keeps lamps dark except for the blinks themselves
            act_nxt  = act_blink;
            link_nxt = link_blink;
        end else begin
            act_nxt  = !act_blink;
            link_nxt = enumerated_r ^ link_blink;
        end
    end

    // registered lamp drive so the pins never glitch on mode changes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lamp_act_r  <= 1'b0;
            lamp_link_r <= 1'b0;
        end else begin
            lamp_act_r  <= act_nxt;
            lamp_link_r <= link_nxt;
        end
    end

    assign lamp_activity  = lamp_act_r;
    assign lamp_link      = lamp_link_r;
    assign reg_rdata      = rdata_r;
    assign reg_rvalid     = rvalid_r;
    assign boot_mode_keep = lamp_mode_boot_r;

endmodule // ilc_lamp_ctrl

// file: shared/ilc_pkg.sv
// constants, encodings and carrier types for the indicator lamp controller
// assumes one 100 MHz clock and a single-word register port driven by the command processor
package ilc_pkg;

    // clock and timebase
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_MS         = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;

    // lamp timing and blink counts; durations in milliseconds (one tick each)
    localparam int unsigned BOOT_BLINK_MS   = 1000;
    localparam int unsigned RAPID_HALF_MS   = 50;
    localparam int unsigned LINK_RATE_HZ    = 10;
    localparam int unsigned BLINK_PERIOD_MS = 1000 / LINK_RATE_HZ;
    localparam int unsigned BLINK_ON_MS     = BLINK_PERIOD_MS / 2;
    localparam int unsigned POLL_PERIOD_MS  = 1000;
    localparam int unsigned UNISON_HALF_MS  = 250;
    localparam int unsigned ENUM_BLINKS     = 3;
    localparam int unsigned POLL_BLINKS     = 2;
    localparam int unsigned PEND_W          = 3;

    // register addresses
    localparam logic [15:0] ADDR_MANUAL_LINK     = 16'h0bae;
    localparam logic [15:0] ADDR_MANUAL_ACTIVITY = 16'h0baf;
    localparam logic [15:0] ADDR_LAMP_MODE       = 16'hbb86;
    localparam logic [15:0] ADDR_LAMP_MODE_BOOT  = 16'hbbb8;

    // lamp mode encodings
    localparam logic [15:0] MODE_OFF    = 16'h0000;
    localparam logic [15:0] MODE_NORMAL = 16'h0001;
    localparam logic [15:0] MODE_LOW    = 16'h0002;
    localparam logic [15:0] MODE_MANUAL = 16'h0003;
    localparam logic [15:0] MODE_RESET  = MODE_NORMAL;

    // manual lamp register field
    localparam int unsigned MANUAL_ON_BIT = 0;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ilc_reg_req_type;

    typedef struct packed {
        logic script_access;
        logic stream_prep;
        logic cmd_packet;
        logic stream_xfer;
        logic enum_done;
    } ilc_event_type;

    typedef struct packed {
        logic       checksum_busy;
        logic       image_copy;
        logic       dashboard_poll;
        logic [2:0] fw_stage;
    } ilc_status_type;

endpackage

// file: verification/ilc_lamp_model.sv
// the two indicator lamps as seen from the panel: counts every change of each lamp
// assumes lamp inputs are high for lit and settle on clk; clr zeroes both counts
module ilc_lamp_model (
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        lamp_link,
    input  wire logic        lamp_activity,
    output logic [15:0]      link_t,
    output logic [15:0]      act_t
);
    timeunit 1ns;
    timeprecision 1ps;
    logic link_q;
    logic act_q;

    // a lamp keeps no state, so only its changes are worth counting
    always_ff @(posedge clk) begin
        link_q <= lamp_link;
        act_q  <= lamp_activity;
        if (clr) begin
            link_t <= '0;
            act_t  <= '0;
        end else begin
            link_t <= link_t + 16'(lamp_link !== link_q);
            act_t  <= act_t + 16'(lamp_activity !== act_q);
        end
    end
endmodule // ilc_lamp_model

// file: verification/ilc_lamp_sva.sv
// checker for the lamp controller: register port, manual drive, link blink spacing
// assumes binding to ilc_lamp_ctrl, one clock and a synchronous active-low reset
module ilc_lamp_sva
    import ilc_pkg::*;
#(
    parameter int unsigned TICK_DIV = 100000
) (
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire ilc_pkg::ilc_reg_req_type reg_req,
    input wire logic [15:0]              reg_rdata,
    input wire logic                     reg_rvalid,
    input wire ilc_pkg::ilc_event_type   ev,
    input wire ilc_pkg::ilc_status_type  st,
    input wire logic [15:0]              boot_mode_stored,
    input wire logic [15:0]              boot_mode_keep,
    input wire logic                     lamp_link,
    input wire logic                     lamp_activity
);
    localparam int unsigned MIN_GAP  = 49 * TICK_DIV;
    localparam int unsigned CALM_CYC = 1002 * TICK_DIV + 8;
    localparam int unsigned BUSY_CYC = 101 * TICK_DIV + 8;
    logic        cap_r;
    logic [15:0] mode_r;
    logic [31:0] calm_r;
    logic [31:0] gap_r;
    logic        quiet;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // shadow of the active mode: retained value on the first edge, then writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cap_r  <= 1'b1;
            mode_r <= MODE_RESET;
        end else begin
            cap_r <= 1'b0;
            if (cap_r) begin
                mode_r <= boot_mode_stored;
            end else if (reg_req.wr && reg_req.addr == ADDR_LAMP_MODE) begin
                mode_r <= reg_req.wdata;
            end
        end
    end

    // a blink cut short by a pattern change is legal, so wait a whole blink after one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            calm_r <= CALM_CYC;
        end else if ((ev.enum_done || reg_req.wr || st != '0) && calm_r < BUSY_CYC) begin
            calm_r <= BUSY_CYC;
        end else if (calm_r != 0) begin
            calm_r <= calm_r - 1;
        end
    end
    assign quiet = calm_r == 0 && mode_r == MODE_NORMAL;

    // cycles since the link lamp last changed, parked at the floor outside quiet spells
    always_ff @(posedge clk) begin
        if (!rst_n || !quiet) begin
            gap_r <= MIN_GAP;
        end else if ($changed(lamp_link)) begin
            gap_r <= '0;
        end else if (gap_r < MIN_GAP) begin
            gap_r <= gap_r + 1;
        end
    end

    sequence s_rd(logic [15:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    sequence s_man_wr(logic [15:0] a);
        reg_req.wr && reg_req.addr == a && mode_r == MODE_MANUAL ##1 !reg_req.wr;
    endsequence

    AST_RVALID_AFTER_RD: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read strobe got no valid");
    AST_RVALID_CAUSE: assert property (reg_rvalid |-> $past(reg_req.rd))
        else $error("valid without a read");
    AST_RESET_STATE: assert property ($rose(rst_n) |-> boot_mode_keep == 16'h0001
        && !lamp_link && !lamp_activity && !reg_rvalid)
        else $error("bad state at reset release");
    AST_MODE_READBACK: assert property (s_rd(ADDR_LAMP_MODE) |=> reg_rdata == $past(mode_r))
        else $error("lamp mode readback wrong");
    AST_WO_READ_ZERO: assert property (s_rd(ADDR_MANUAL_LINK) or s_rd(ADDR_MANUAL_ACTIVITY)
        |=> reg_rdata == 16'h0000)
        else $error("write-only register read nonzero");
    AST_MANUAL_LINK: assert property (s_man_wr(ADDR_MANUAL_LINK)
        |-> ##1 lamp_link == $past(reg_req.wdata[0], 2))
        else $error("manual link lamp wrong");
    AST_MANUAL_ACT: assert property (s_man_wr(ADDR_MANUAL_ACTIVITY)
        |-> ##1 lamp_activity == $past(reg_req.wdata[0], 2))
        else $error("manual activity lamp wrong");
    AST_OFF_DARK: assert property (mode_r == MODE_OFF [*3] |-> !lamp_link && !lamp_activity)
        else $error("lamp lit in off mode");
    AST_LINK_SPACING: assert property (quiet && $changed(lamp_link) |-> gap_r >= MIN_GAP - 1)
        else $error("link lamp changed too soon");
endmodule // ilc_lamp_sva

bind ilc_lamp_ctrl ilc_lamp_sva #(.TICK_DIV(TICK_DIV)) sva_u (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .ev(ev), .st(st), .boot_mode_stored(boot_mode_stored),
    .boot_mode_keep(boot_mode_keep), .lamp_link(lamp_link), .lamp_activity(lamp_activity)
);

// file: verification/tb.sv
// self-checking bench for the lamp controller: register port, patterns, blink counts
// assumes a short tick (two cycles) so that every millisecond figure scales down
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ilc_pkg::*;
    localparam int unsigned TD    = 2;
    localparam int unsigned BLINK = BLINK_PERIOD_MS * TD;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] exp;
    } ilc_row_type;
    localparam ilc_row_type ROWS [5] = '{
        '{ADDR_LAMP_MODE_BOOT, 16'h0002, 16'h0002},
        '{16'h1234, 16'h00aa, 16'h0000},
        '{ADDR_MANUAL_LINK, 16'h0001, 16'h0000},
        '{ADDR_MANUAL_ACTIVITY, 16'h0001, 16'h0000},
        '{ADDR_LAMP_MODE, MODE_NORMAL, MODE_NORMAL}};
    logic            clk, rst_n, clr, rvalid, l_link, l_act;
    ilc_reg_req_type req;
    ilc_event_type   ev;
    ilc_status_type  st;
    logic [15:0]     boot_st, keep, rdata, got, link_t, act_t;
    int              errors, cmp_count, cyc;

    ilc_lamp_ctrl #(.TICK_DIV(TD)) dut_u (
        .clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .ev(ev), .st(st), .boot_mode_stored(boot_st), .boot_mode_keep(keep),
        .lamp_link(l_link), .lamp_activity(l_act));
    ilc_lamp_model lamps_u (
        .clk(clk), .clr(clr), .lamp_link(l_link), .lamp_activity(l_act),
        .link_t(link_t), .act_t(act_t));

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // the run needs about 12600 cycles; a hang is cut off well beyond that
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            $display("FAIL timeout expected end seen hang");
            close_out();
        end
    end

    // inputs always move one time unit after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // a spare cycle after each write keeps back-to-back writes from colliding
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        step(1);
        req = '0;
        step(1);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        step(1);
        req = '0;
        check("rvalid", 16'h0001, {15'h0, rvalid});
        d = rdata;
        step(1);
    endtask
    task automatic pulse(input ilc_event_type e, input int n);
        ev = e;
        step(n);
        ev = '0;
        step(1);
    endtask
    task automatic zero();
        clr = 1'b1;
        step(1);
        clr = 1'b0;
    endtask

    initial begin
        rst_n = 1'b0;
        clr = 1'b1;
        req = '0;
        ev = '0;
        st = '0;
        boot_st = MODE_NORMAL;
        errors = 0;
        cmp_count = 0;
        cyc = 0;
        step(20);
        check("keep_rst", MODE_RESET, keep);
        check("lamps_rst", 16'h0000, {14'h0, l_link, l_act});
        rst_n = 1'b1;
        step(1);
        clr = 1'b0;
        rd(ADDR_LAMP_MODE, got);
        check("mode_boot", MODE_NORMAL, got);
        // ordinary register cases, written then read back
        foreach (ROWS[i]) begin
            wr(ROWS[i].addr, ROWS[i].wdata);
            rd(ROWS[i].addr, got);
            check("row", ROWS[i].exp, got);
        end
        check("keep", 16'h0002, keep);
        step(1800);
        check("boot_blink", 16'h0001, {15'h0, link_t >= 16 && act_t >= 16});
        step(400);
        check("after_boot", 16'h0001, {14'h0, l_link, l_act});
        zero();
        pulse(ilc_event_type'(5'h01), 1);
        step(3 * BLINK + 100);
        check("enum_on", 16'h0001, {15'h0, l_link});
        check("enum_blinks", 16'h0001, {15'h0, link_t >= 6});
        zero();
        step(300);
        check("idle", 16'h0003, {14'h0, l_link, l_act});
        check("idle_still", 16'h0000, link_t | act_t);
        // manual drive, the last pattern differs from the normal steady state
        wr(ADDR_LAMP_MODE, MODE_MANUAL);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_MANUAL_LINK, {15'h7f00, i[0]});
            wr(ADDR_MANUAL_ACTIVITY, {15'h0, i[1]});
            check("manual", {14'h0, i[0], i[1]}, {14'h0, l_link, l_act});
        end
        // writes outside manual must not reach the held levels (link 0, activity 1)
        wr(ADDR_LAMP_MODE, MODE_NORMAL);
        wr(ADDR_MANUAL_LINK, 16'h0001);
        wr(ADDR_MANUAL_ACTIVITY, 16'h0000);
        step(4);
        check("ignored", 16'h0003, {14'h0, l_link, l_act});
        wr(ADDR_LAMP_MODE, MODE_MANUAL);
        check("ignored_kept", 16'h0001, {14'h0, l_link, l_act});
        // low power: dark apart from the blinks themselves
        wr(ADDR_LAMP_MODE, MODE_LOW);
        check("low_dark", 16'h0000, {14'h0, l_link, l_act});
        pulse(ilc_event_type'(5'h14), 1);
        step(50);
        check("low_blink", 16'h0003, {14'h0, l_link, l_act});
        // back to normal; let the leftover blink finish before counting packets
        wr(ADDR_LAMP_MODE, MODE_NORMAL);
        step(300);
        // five back-to-back packets from both sources
        zero();
        pulse(ilc_event_type'(5'h04), 3);
        pulse(ilc_event_type'(5'h02), 2);
        step(50);
        check("link_blink", 16'h0000, {15'h0, l_link});
        step(5 * BLINK + 100);
        check("per_packet", 16'h000a, link_t);
        zero();
        pulse(ilc_event_type'(5'h10), 1);
        pulse(ilc_event_type'(5'h08), 1);
        step(50);
        check("act_blink", 16'h0000, {15'h0, l_act});
        step(500);
        check("act_count", 16'h0004, act_t);
        zero();
        st = ilc_status_type'(6'h08);
        step(POLL_PERIOD_MS * TD + 400);
        st = '0;
        check("poll_link", 16'h0001, {15'h0, link_t >= 4});
        check("poll_act", 16'h0000, act_t);
        step(300);
        // checksum then image copy: lamps in unison, then opposed
        for (int m = 0; m < 2; m++) begin
            st = m ? ilc_status_type'(6'h10) : ilc_status_type'(6'h20);
            zero();
            repeat (12) begin
                step(100);
                check("pair", {15'h0, m[0]}, {15'h0, l_link ^ l_act});
            end
            check("pair_moves", 16'h0001, {15'h0, link_t > 0});
            st = '0;
            step(300);
        end
        zero();
        st = ilc_status_type'(6'h03);
        step(7 * BLINK);
        check("stage_blinks", 16'h0006, act_t);
        st = '0;
        // second power cycle with the lamps retained off
        rst_n = 1'b0;
        boot_st = MODE_OFF;
        step(20);
        rst_n = 1'b1;
        step(1);
        rd(ADDR_LAMP_MODE, got);
        check("mode_off", MODE_OFF, got);
        check("keep_off", MODE_OFF, keep);
        step(100);
        check("dark", 16'h0000, {14'h0, l_link, l_act});
        close_out();
    end
endmodule // tb
